/* dfte_regs.vh */
// Constants of the drive fault trip encoder: fault codes, state codes, widths and counts.
// Assumes inclusion by bare name from the design files of this block.
`ifndef DFTE_REGS_VH
`define DFTE_REGS_VH

`define DFTE_CODE_W 7
`define DFTE_STATE_W 4
`define DFTE_HIST_DEPTH 6

`define DFTE_CODE_NONE 7'h00
`define DFTE_CODE_E01 7'h01
`define DFTE_CODE_E02 7'h02
`define DFTE_CODE_E03 7'h03
`define DFTE_CODE_E04 7'h04
`define DFTE_CODE_E05 7'h05
`define DFTE_CODE_E06 7'h06
`define DFTE_CODE_E07 7'h07
`define DFTE_CODE_E08 7'h08
`define DFTE_CODE_E09 7'h09
`define DFTE_CODE_E10 7'h0A
`define DFTE_CODE_E11 7'h0B
`define DFTE_CODE_E12 7'h0C

`define DFTE_ST_RESET 4'h0
`define DFTE_ST_STOP 4'h1
`define DFTE_ST_DECEL 4'h2
`define DFTE_ST_STEADY 4'h3
`define DFTE_ST_ACCEL 4'h4
`define DFTE_ST_ZERO_STOP 4'h5
`define DFTE_ST_START 4'h6
`define DFTE_ST_DC_BRAKE 4'h7
`define DFTE_ST_CUR_LIMIT 4'h8
`define DFTE_ST_AUTOTUNE 4'h9

`define DFTE_PIN_COUNT 12
`define DFTE_STARTUP_W 2
`define DFTE_STARTUP_SAMPLE 2'h2
`define DFTE_STARTUP_DONE 2'h3

`endif

/* dfte_fault_history.v */
// Six-deep fault history: newest entry in slot 0, older entries shift toward the last slot.
// Assumes push_i is a one-cycle pulse from logic on the same clock.
`default_nettype none
`include "dfte_regs.vh"

module dfte_fault_history #(
  parameter DEPTH = `DFTE_HIST_DEPTH,
  parameter CODE_W = `DFTE_CODE_W,
  parameter STATE_W = `DFTE_STATE_W
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire push_i,
  input wire [CODE_W-1:0] code_i,
  input wire [STATE_W-1:0] state_i,
  output wire [DEPTH*CODE_W-1:0] hist_code_o,
  output wire [DEPTH*STATE_W-1:0] hist_state_o,
  output wire [DEPTH-1:0] hist_valid_o
);

  reg [CODE_W-1:0] code_reg [0:DEPTH-1];
  reg [STATE_W-1:0] state_reg [0:DEPTH-1];
  reg [DEPTH-1:0] valid_reg;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_slot
      always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          code_reg[i] <= {CODE_W{1'b0}};
          state_reg[i] <= {STATE_W{1'b0}};
          valid_reg[i] <= 1'b0;
        end else if (push_i) begin
          if (i == 0) begin
            code_reg[i] <= code_i;
            state_reg[i] <= state_i;
            valid_reg[i] <= 1'b1;
          end else begin
            code_reg[i] <= code_reg[(i == 0) ? 0 : i-1];
            state_reg[i] <= state_reg[(i == 0) ? 0 : i-1];
            valid_reg[i] <= valid_reg[(i == 0) ? 0 : i-1];
          end
        end
      end
      assign hist_code_o[i*CODE_W +: CODE_W] = code_reg[i];
      assign hist_state_o[i*STATE_W +: STATE_W] = state_reg[i];
    end
  endgenerate

  assign hist_valid_o = valid_reg;

endmodule // dfte_fault_history

`default_nettype wire

/* dfte_trip_encoder.v */
// Fault trip and message encoder of a motor drive: collects fault inputs, trips the output stage,
// latches one fault code with the drive state and keeps a short fault history.
// Assumes fault, key and reset inputs come from pins; drive_state_i comes from logic on mclk_i.
//
// Overview of operation
// - Overcurrent, overvoltage or undervoltage disables the power output at once.
// - Trip and disabled output hold until off key or fault reset input.
// - Faults that carry state also report the single-digit drive state code.
// - State codes: 0 reset up to 9 autotuning, as the state encoding lists.
// - Overcurrent code by state: E01 steady, E02 decel, E03 accel, E04 standstill.
// - Motor overload protection trips the output and reports E05.
// - Braking transistor duty too high turns it off and reports E06.
// - Regenerative overvoltage trips the output and reports E07.
// - Memory failure reports E08, also at power-up after power loss under reset.
// - DC voltage too low trips the output and reports E09.
// - Current transformer failure disconnects the output and reports E10.
// - Processor malfunction trips the output and reports E11.
// - Asserted external fault input trips the output and reports E12.
// - Six newest faults kept; new fault enters newest slot, older ones shift.
`default_nettype none
`include "dfte_regs.vh"

module dfte_trip_encoder #(
  parameter DEPTH = `DFTE_HIST_DEPTH
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire overcurrent_i,
  input wire motor_overload_i,
  input wire brake_duty_high_i,
  input wire regen_overvoltage_i,
  input wire memory_fail_i,
  input wire undervoltage_i,
  input wire ct_fail_i,
  input wire cpu_fail_i,
  input wire external_fault_input_i,
  input wire off_key_i,
  input wire fault_reset_i,
  input wire reset_at_powerdown_i,
  input wire [`DFTE_STATE_W-1:0] drive_state_i,
  output wire power_enable_o,
  output wire brake_enable_o,
  output wire trip_o,
  output wire [`DFTE_CODE_W-1:0] fault_code_o,
  output wire [`DFTE_STATE_W-1:0] fault_state_o,
  output wire state_valid_o,
  output wire new_fault_o,
  output wire fault_reset_active_o,
  output wire [DEPTH*`DFTE_CODE_W-1:0] hist_code_o,
  output wire [DEPTH*`DFTE_STATE_W-1:0] hist_state_o,
  output wire [DEPTH-1:0] hist_valid_o
);

  localparam [2:0] ST_INIT = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_TRIP = 3'b100;

  localparam integer P_OC = 0;
  localparam integer P_OVL = 1;
  localparam integer P_BRK = 2;
  localparam integer P_REGEN = 3;
  localparam integer P_MEM = 4;
  localparam integer P_UV = 5;
  localparam integer P_CT = 6;
  localparam integer P_CPU = 7;
  localparam integer P_EXT = 8;
  localparam integer P_OFF = 9;
  localparam integer P_RST = 10;
  localparam integer P_PWRDN = 11;

  // Overcurrent code follows the drive state; every state that is not ramping or steady counts as standstill.
  function [`DFTE_CODE_W-1:0] oc_code;
    input [`DFTE_STATE_W-1:0] st;
    begin
      case (st)
        `DFTE_ST_STEADY: oc_code = `DFTE_CODE_E01;
        `DFTE_ST_DECEL: oc_code = `DFTE_CODE_E02;
        `DFTE_ST_ACCEL: oc_code = `DFTE_CODE_E03;
        default: oc_code = `DFTE_CODE_E04;
      endcase
    end
  endfunction

  // Memory and processor failures leave the recorded state untrustworthy, so they carry none.
  function has_state;
    input [`DFTE_CODE_W-1:0] code;
    begin
      case (code)
        `DFTE_CODE_E08: has_state = 1'b0;
        `DFTE_CODE_E11: has_state = 1'b0;
        `DFTE_CODE_NONE: has_state = 1'b0;
        default: has_state = 1'b1;
      endcase
    end
  endfunction

  wire [`DFTE_PIN_COUNT-1:0] pins;
  reg [`DFTE_PIN_COUNT-1:0] sync1_reg;
  reg [`DFTE_PIN_COUNT-1:0] sync2_reg;
  reg off_prev_reg;
  reg [`DFTE_STARTUP_W-1:0] startup_reg;
  reg pwrup_mem_reg;
  reg pwrup_mem_next;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg power_enable_reg;
  reg power_enable_next;
  reg brake_enable_reg;
  reg brake_enable_next;
  reg [`DFTE_CODE_W-1:0] fault_code_reg;
  reg [`DFTE_CODE_W-1:0] fault_code_next;
  reg [`DFTE_STATE_W-1:0] fault_state_reg;
  reg [`DFTE_STATE_W-1:0] fault_state_next;
  reg state_valid_reg;
  reg state_valid_next;
  reg new_fault_reg;
  reg new_fault_next;
  reg reset_active_reg;
  reg [`DFTE_CODE_W-1:0] cand_code;
  wire any_fault;
  wire ack;
  wire off_press;
  wire mem_fault;

  assign pins = {reset_at_powerdown_i, fault_reset_i, off_key_i, external_fault_input_i, cpu_fail_i,
                 ct_fail_i, undervoltage_i, memory_fail_i, regen_overvoltage_i, brake_duty_high_i,
                 motor_overload_i, overcurrent_i};

  // Every pin passes two flip-flops; only the second stage feeds logic.
  genvar g;
  generate
    for (g = 0; g < `DFTE_PIN_COUNT; g = g + 1) begin : g_sync
      always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= pins[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      off_prev_reg <= 1'b0;
      reset_active_reg <= 1'b0;
    end else begin
      off_prev_reg <= sync2_reg[P_OFF];
      reset_active_reg <= sync2_reg[P_RST];
    end
  end

  assign off_press = sync2_reg[P_OFF] & ~off_prev_reg;
  assign ack = off_press | sync2_reg[P_RST];

  // The power-down flag is caught after release, once it has passed the synchroniser.
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      startup_reg <= {`DFTE_STARTUP_W{1'b0}};
      pwrup_mem_reg <= 1'b0;
    end else begin
      if (startup_reg != `DFTE_STARTUP_DONE) begin
        startup_reg <= startup_reg + {{(`DFTE_STARTUP_W-1){1'b0}}, 1'b1};
      end
      pwrup_mem_reg <= pwrup_mem_next;
    end
  end

  always @* begin
    pwrup_mem_next = pwrup_mem_reg;
    if (startup_reg == `DFTE_STARTUP_SAMPLE) begin
      pwrup_mem_next = sync2_reg[P_PWRDN];
    end else if (state_reg == ST_TRIP && fault_code_reg == `DFTE_CODE_E08) begin
      pwrup_mem_next = 1'b0;
    end
  end

  assign mem_fault = sync2_reg[P_MEM] | pwrup_mem_reg;

  assign any_fault = sync2_reg[P_OC] | sync2_reg[P_OVL] | sync2_reg[P_BRK] | sync2_reg[P_REGEN] |
                     mem_fault | sync2_reg[P_UV] | sync2_reg[P_CT] | sync2_reg[P_CPU] |
                     sync2_reg[P_EXT];

  // Lowest code wins when several faults arrive together.
  always @* begin
    cand_code = `DFTE_CODE_NONE;
    if (sync2_reg[P_OC]) begin
      cand_code = oc_code(drive_state_i);
    end else if (sync2_reg[P_OVL]) begin
      cand_code = `DFTE_CODE_E05;
    end else if (sync2_reg[P_BRK]) begin
      cand_code = `DFTE_CODE_E06;
    end else if (sync2_reg[P_REGEN]) begin
      cand_code = `DFTE_CODE_E07;
    end else if (mem_fault) begin
      cand_code = `DFTE_CODE_E08;
    end else if (sync2_reg[P_UV]) begin
      cand_code = `DFTE_CODE_E09;
    end else if (sync2_reg[P_CT]) begin
      cand_code = `DFTE_CODE_E10;
    end else if (sync2_reg[P_CPU]) begin
      cand_code = `DFTE_CODE_E11;
    end else if (sync2_reg[P_EXT]) begin
      cand_code = `DFTE_CODE_E12;
    end
  end

  always @* begin
    state_next = state_reg;
    power_enable_next = 1'b0;
    brake_enable_next = 1'b0;
    fault_code_next = fault_code_reg;
    fault_state_next = fault_state_reg;
    state_valid_next = state_valid_reg;
    new_fault_next = 1'b0;
    case (state_reg)
      ST_INIT: begin
        if (startup_reg == `DFTE_STARTUP_DONE) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (any_fault) begin
          state_next = ST_TRIP;
          fault_code_next = cand_code;
          fault_state_next = drive_state_i;
          state_valid_next = has_state(cand_code);
          new_fault_next = 1'b1;
        end else begin
          // A held fault reset keeps the drive in standby without tripping it.
          power_enable_next = ~sync2_reg[P_RST];
          brake_enable_next = ~sync2_reg[P_RST];
        end
      end
      ST_TRIP: begin
        // Output and braking transistor stay off for the whole trip.
        if (ack && any_fault) begin
          // A fault present during the acknowledge is a new trip, not lost.
          fault_code_next = cand_code;
          fault_state_next = drive_state_i;
          state_valid_next = has_state(cand_code);
          new_fault_next = 1'b1;
        end else if (ack) begin
          state_next = ST_ARMED;
          fault_code_next = `DFTE_CODE_NONE;
          fault_state_next = `DFTE_ST_RESET;
          state_valid_next = 1'b0;
        end
        // Without an acknowledge later faults are ignored here.
      end
      default: begin
        state_next = ST_INIT;
      end
    endcase
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_INIT;
      power_enable_reg <= 1'b0;
      brake_enable_reg <= 1'b0;
      fault_code_reg <= `DFTE_CODE_NONE;
      fault_state_reg <= `DFTE_ST_RESET;
      state_valid_reg <= 1'b0;
      new_fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      power_enable_reg <= power_enable_next;
      brake_enable_reg <= brake_enable_next;
      fault_code_reg <= fault_code_next;
      fault_state_reg <= fault_state_next;
      state_valid_reg <= state_valid_next;
      new_fault_reg <= new_fault_next;
    end
  end

  dfte_fault_history #(
    .DEPTH(DEPTH),
    .CODE_W(`DFTE_CODE_W),
    .STATE_W(`DFTE_STATE_W)
  ) u_history (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .push_i(new_fault_reg),
    .code_i(fault_code_reg),
    .state_i(fault_state_reg),
    .hist_code_o(hist_code_o),
    .hist_state_o(hist_state_o),
    .hist_valid_o(hist_valid_o)
  );

  assign power_enable_o = power_enable_reg;
  assign brake_enable_o = brake_enable_reg;
  assign trip_o = state_reg[2];
  assign fault_code_o = fault_code_reg;
  assign fault_state_o = fault_state_reg;
  assign state_valid_o = state_valid_reg;
  assign new_fault_o = new_fault_reg;
  assign fault_reset_active_o = reset_active_reg;

endmodule // dfte_trip_encoder

`default_nettype wire

/* dfte_trip_encoder_asserts.sv */
// Checker for the trip encoder: trip timing, latched code and history push, seen at the ports.
// Assumes fault and acknowledge pins reach the trip logic two edges after they are sampled.
`default_nettype none
`include "dfte_regs.vh"
module dfte_trip_encoder_asserts #(
  parameter DEPTH = 6
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic overcurrent_i,
  input wire logic regen_overvoltage_i,
  input wire logic undervoltage_i,
  input wire logic off_key_i,
  input wire logic fault_reset_i,
  input wire logic [`DFTE_STATE_W-1:0] drive_state_i,
  input wire logic power_enable_o,
  input wire logic brake_enable_o,
  input wire logic trip_o,
  input wire logic [`DFTE_CODE_W-1:0] fault_code_o,
  input wire logic [`DFTE_STATE_W-1:0] fault_state_o,
  input wire logic state_valid_o,
  input wire logic new_fault_o,
  input wire logic [DEPTH*`DFTE_CODE_W-1:0] hist_code_o,
  input wire logic [DEPTH-1:0] hist_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_trip_cuts_power: assert property (trip_o |-> !power_enable_o && !brake_enable_o)
    else $error("output stage enabled while tripped");
  a_fault_trips_fast: assert property ((power_enable_o && (overcurrent_i || regen_overvoltage_i || undervoltage_i))
    |-> ##[1:3] trip_o)
    else $error("power fault did not trip in time");
  a_trip_needs_ack: assert property ($fell(trip_o) |-> $past(fault_reset_i, 3) || $past(off_key_i, 3))
    else $error("trip released without acknowledge");
  a_state_valid_kind: assert property (trip_o |-> state_valid_o ==
    !(fault_code_o == `DFTE_CODE_E08 || fault_code_o == `DFTE_CODE_E11))
    else $error("state flag wrong for fault kind");
  a_state_captured: assert property ($rose(trip_o) && state_valid_o |-> fault_state_o == $past(drive_state_i))
    else $error("reported state differs from drive state");
  a_oc_code_state: assert property ($rose(trip_o) && fault_code_o != 7'h00 && fault_code_o <= 7'h04
    |-> fault_code_o == (fault_state_o == 4'h3 ? 7'h01 : fault_state_o == 4'h2 ? 7'h02 :
    fault_state_o == 4'h4 ? 7'h03 : 7'h04))
    else $error("overcurrent code does not match state");
  // The pulse is raised by the same edge that latches the trip, and the history takes it one edge later.
  a_new_fault_once: assert property ($rose(trip_o) |-> new_fault_o ##1 !new_fault_o)
    else $error("new fault pulse missing or too long");
  a_history_push: assert property (new_fault_o |=> hist_valid_o[0] && hist_code_o[6:0] == $past(fault_code_o))
    else $error("history slot 0 not the new fault");
  a_first_code_kept: assert property (trip_o && $past(trip_o) && fault_code_o != $past(fault_code_o)
    |-> $past(fault_reset_i, 3) || $past(off_key_i, 3))
    else $error("latched code replaced while tripped");
  c_trip: cover property ($rose(trip_o));
  c_ack: cover property ($fell(trip_o));
  c_hist_full: cover property (new_fault_o && hist_valid_o[DEPTH-1]);
endmodule // dfte_trip_encoder_asserts
bind dfte_trip_encoder dfte_trip_encoder_asserts #(.DEPTH(DEPTH)) u_asserts (.*);
`default_nettype wire

/* dfte_stage_model.sv */
// Model of the power stage sensors, the outside fault equipment and the operator keypad.
// Assumes bench requests change just after a rising edge of mclk_i.
`default_nettype none
module dfte_stage_model (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic pwr_en_i,
  input wire logic [8:0] req_i,
  input wire logic key_i,
  output logic [8:0] pin_o,
  output logic off_key_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A sensor condition lasts until the stage stops, so a trip is never missed; outside equipment holds its own level.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_o <= 9'h000;
      off_key_o <= 1'b0;
    end else begin
      pin_o <= {req_i[8], req_i[7:0] | (pin_o[7:0] & {8{pwr_en_i}})};
      off_key_o <= key_i;
    end
  end
endmodule // dfte_stage_model
`default_nettype wire

/* test_drive_fault_trip_encoder.sv */
// Self-checking bench of the trip encoder: every fault code, priority, first-fault hold, history, power-up fault.
// Assumes the stage model and the bound checker are compiled beside it.
`default_nettype none
module test_drive_fault_trip_encoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, nrst_i, fault_reset_i, reset_at_powerdown_i, key_req;
  logic [8:0] req;
  logic [3:0] drive_state_i;
  int mismatches = 0;
  int n_tests = 0;
  wire logic [8:0] pins;
  wire logic off_key_i, power_enable_o, brake_enable_o, trip_o, state_valid_o, new_fault_o, fault_reset_active_o;
  wire logic [6:0] fault_code_o;
  wire logic [3:0] fault_state_o;
  wire logic [41:0] hist_code_o;
  wire logic [23:0] hist_state_o;
  wire logic [5:0] hist_valid_o;
  dfte_stage_model u_stage (.mclk_i(mclk_i), .nrst_i(nrst_i), .pwr_en_i(power_enable_o), .req_i(req),
    .key_i(key_req), .pin_o(pins), .off_key_o(off_key_i));
  dfte_trip_encoder DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .overcurrent_i(pins[0]), .motor_overload_i(pins[1]),
    .brake_duty_high_i(pins[2]), .regen_overvoltage_i(pins[3]), .memory_fail_i(pins[4]), .undervoltage_i(pins[5]),
    .ct_fail_i(pins[6]), .cpu_fail_i(pins[7]), .external_fault_input_i(pins[8]), .off_key_i(off_key_i),
    .fault_reset_i(fault_reset_i), .reset_at_powerdown_i(reset_at_powerdown_i), .drive_state_i(drive_state_i),
    .power_enable_o(power_enable_o), .brake_enable_o(brake_enable_o), .trip_o(trip_o), .fault_code_o(fault_code_o),
    .fault_state_o(fault_state_o), .state_valid_o(state_valid_o), .new_fault_o(new_fault_o),
    .fault_reset_active_o(fault_reset_active_o), .hist_code_o(hist_code_o), .hist_state_o(hist_state_o),
    .hist_valid_o(hist_valid_o));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic summarize();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Bounded wait on trip_o or, with pe set, on power_enable_o.
  task automatic wait_sig(input bit pe, input logic lvl);
    int i;
    i = 0;
    while ((pe ? power_enable_o : trip_o) !== lvl) begin
      i++;
      if (i > 40) begin
        mismatches++;
        $display("[ERR] %0t wait ran out", $time);
        summarize();
      end
      tick(1);
    end
  endtask
  task automatic do_reset();
    nrst_i = 1'b0;
    tick(3);
    nrst_i = 1'b1;
  endtask
  task automatic fire(input int b, input logic [3:0] st, input logic [6:0] code, input logic sv);
    logic [6:0] prev;
    prev = hist_code_o[6:0];
    drive_state_i = st;
    req[b] = 1'b1;
    tick(1);
    req[b] = 1'b0;
    wait_sig(0, 1'b1);
    check(power_enable_o === 1'b0 && brake_enable_o === 1'b0, "stage still on");
    check(fault_code_o === code, "fault code");
    check(state_valid_o === sv && (!sv || fault_state_o === st), "state code");
    check(new_fault_o === 1'b1, "new fault pulse missing");
    tick(1);
    check(hist_code_o[6:0] === code && hist_code_o[13:7] === prev, "history shift");
    check(new_fault_o === 1'b0 && (!sv || hist_state_o[3:0] === st), "history state or pulse length");
  endtask
  task automatic ack_reset();
    fault_reset_i = 1'b1;
    wait_sig(0, 1'b0);
    check(fault_code_o === 7'h00 && state_valid_o === 1'b0, "code not cleared");
    tick(3);
    check(power_enable_o === 1'b0, "standby lost while reset held");
    check(fault_reset_active_o === 1'b1, "fault reset not reported");
    fault_reset_i = 1'b0;
    wait_sig(1, 1'b1);
  endtask
  task automatic sc_codes();
    for (int s = 0; s < 10; s++) begin
      fire(0, s[3:0], s == 3 ? 7'h01 : s == 2 ? 7'h02 : s == 4 ? 7'h03 : 7'h04, 1'b1);
      ack_reset();
    end
    for (int b = 1; b < 9; b++) begin
      fire(b, 4'h3, 7'(b + 4), !(b == 4 || b == 7));
      ack_reset();
    end
    check(hist_valid_o === 6'h3F && hist_code_o[41:35] === 7'h07, "oldest slot");
  endtask
  task automatic sc_first_kept();
    drive_state_i = 4'h3;
    req[8] = 1'b1;
    wait_sig(0, 1'b1);
    req[5] = 1'b1;
    tick(1);
    req[5] = 1'b0;
    tick(4);
    check(fault_code_o === 7'h0C && hist_code_o[6:0] === 7'h0C, "first fault replaced");
    req[8] = 1'b0;
    tick(1);
    key_req = 1'b1;
    wait_sig(0, 1'b0);
    key_req = 1'b0;
    check(fault_code_o === 7'h00, "off key did not clear");
    wait_sig(1, 1'b1);
  endtask
  task automatic sc_lowest();
    drive_state_i = 4'h4;
    req = 9'h120;
    tick(1);
    req = 9'h000;
    wait_sig(0, 1'b1);
    check(fault_code_o === 7'h09, "lowest code not chosen");
    ack_reset();
  endtask
  task automatic sc_powerup();
    reset_at_powerdown_i = 1'b1;
    do_reset();
    wait_sig(0, 1'b1);
    reset_at_powerdown_i = 1'b0;
    check(fault_code_o === 7'h08 && state_valid_o === 1'b0, "power-up memory fault");
    ack_reset();
  endtask
  initial begin
    nrst_i = 1'b0;
    req = 9'h000;
    key_req = 1'b0;
    fault_reset_i = 1'b0;
    reset_at_powerdown_i = 1'b0;
    drive_state_i = 4'h1;
    #1;
    do_reset();
    wait_sig(1, 1'b1);
    sc_codes();
    sc_first_kept();
    sc_lowest();
    sc_powerup();
    summarize();
  end
endmodule // test_drive_fault_trip_encoder
`default_nettype wire
